// ---- qpot_pkg.sv ----
// shared constants and types for the quad potentiometer serial slave port
package qpot_pkg;

  // clock rates and timing figures
  localparam int MCLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 32;
  localparam int NOISE_REJECT_NS = 50;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int POWERUP_TO_READ_DELAY_MS = 1;
  localparam int POWERUP_TO_WRITE_DELAY_MS = 1;
  // one sample more than a sub-limit pulse can ever span
  localparam int FILT_CYCLES = (NOISE_REJECT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
  // longest time, so rounded down
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * 1000000 / MCLK_PERIOD_NS;

  // geometry
  localparam int NUM_POTS = 4;
  localparam int NUM_NV_PER_POT = 4;
  localparam int WIPER_W = 6;

  // address byte layout
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 4;
  localparam int ADDR_STRAP_MSB = 3;
  localparam int ADDR_STRAP_LSB = 0;
  // device type code: arbitrary value
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;

  // instruction byte layout
  localparam int INSTR_OP_MSB = 7;
  localparam int INSTR_OP_LSB = 4;
  localparam int INSTR_REG_MSB = 3;
  localparam int INSTR_REG_LSB = 2;
  localparam int INSTR_POT_MSB = 1;
  localparam int INSTR_POT_LSB = 0;

  // opcodes of the three-byte instructions
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_NV = 4'hb;
  localparam logic [3:0] OP_WR_NV = 4'hc;

  // reset values and the bit count of a byte
  localparam logic [5:0] NV_RESET = 6'h20;
  localparam logic [5:0] WIPER_RESET = 6'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_RX = 6'h02,
    L_ACK = 6'h04,
    L_TX = 6'h08,
    L_RACK = 6'h10,
    L_IGN = 6'h20
  } qpot_lstate_type;

  // word handed from link domain to core domain
  typedef struct packed {
    logic commit;
    logic [7:0] instr;
    logic [7:0] data;
  } qpot_req_type;

endpackage

// ---- qpot_in_filter.sv ----
// two-flop synchroniser plus stability filter for slow bus inputs
`timescale 1ns/10ps
module qpot_in_filter
  import qpot_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int STABLE_CYCLES = FILT_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // raw and cleaned lines
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_clean
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

  genvar gb;
  generate
    for (gb = 0; gb < WIDTH; gb++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic out_reg;
      logic [CW-1:0] cnt_reg;
      wire differs = s2_reg != out_reg;
      wire settled = differs && (cnt_reg == CNT_LAST);
      // lines idle high, so filter comes out of reset released
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          out_reg <= 1'b1;
          cnt_reg <= '0;
        end else begin
          s1_reg <= i_raw[gb];
          s2_reg <= s1_reg;
          cnt_reg <= (differs && !settled) ? cnt_reg + 1'b1 : '0;
          if (settled) begin
            out_reg <= s2_reg;
          end
        end
      end
      assign o_clean[gb] = out_reg;
    end
  endgenerate
endmodule

// ---- qpot_i2c_slave_port.sv ----
// serial slave port of a quad programmable potentiometer
//
// Summary of operation
// - start is data falling while clock high; every command begins with it
// - stop is data rising while clock high
// - data changes while clock high are start or stop, never data bits
// - port drives nothing until a valid start is seen
// - first byte: four type bits then four bits matching the straps
// - receiver pulls data low on the ninth clock as acknowledge
// - matched address is acknowledged unless programming, and every write byte after it unless protected
// - read: send 8 bits, release, sample master acknowledge, go on if given
// - no master acknowledge: stop sending, release line, wait for stop
// - write is address, instruction, data, each acknowledged, then stop
// - stop of a non-volatile write starts a programming cycle of at most 5 ms
// - during programming the port ignores the bus and acknowledges nothing
// - host polls with start plus address; acknowledge returns when done
// - write-protect low makes non-volatile registers read only
// - under protection address and instruction acked, data not, no programming
// - protect going low after programming began does not disturb it
// - pulses shorter than 50 ns on clock and data are rejected
// - instruction: opcode high nibble, register select, then pot select
// - each wiper loads from its pot's first non-volatile setting at power-up
`timescale 1ns/10ps
module qpot_i2c_slave_port
  import qpot_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // core clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus sampling clock
  input wire logic i_link_clk,
  // serial bus, data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // straps and protection
  input wire logic i_addr_strap_0,
  input wire logic i_addr_strap_1,
  input wire logic i_addr_strap_2,
  input wire logic i_addr_strap_3,
  input wire logic i_wp_n,
  // potentiometer side
  output logic [NUM_POTS-1:0][WIPER_W-1:0] o_wiper_pos,
  output logic o_prog_busy
);
  localparam int CW = $clog2(PROG_CYCLES_P + 1);
  localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES_P - 1);

  // ---------------- link domain ----------------
  logic [1:0] clean;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [3:0] strap_s1_reg;
  logic [3:0] strap_s2_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic busy_s1_reg;
  logic busy_s2_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  // core-side answer toggle, declared here as the link synchroniser reads it
  logic ack_tgl_reg;
  qpot_lstate_type lstate_reg, lstate_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [1:0] byte_idx_reg, byte_idx_next;
  logic [7:0] shreg_reg, shreg_next;
  logic [7:0] instr_reg, instr_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] tx_reg, tx_next;
  logic is_read_reg, is_read_next;
  logic wr_pend_reg, wr_pend_next;
  logic oe_n_reg, oe_n_next;
  logic req_tgl_reg, req_tgl_next;
  qpot_req_type req_reg, req_next;
  logic [7:0] rd_word;

  qpot_in_filter #(
    .WIDTH(2),
    .STABLE_CYCLES(FILT_CYCLES)
  ) u_filter (
    .i_clk(i_link_clk),
    .i_rst(i_rst),
    .i_raw({i_scl, i_sda}),
    .o_clean(clean)
  );

  wire scl_f = clean[1];
  wire sda_f = clean[0];
  wire scl_rise = scl_f && !scl_d_reg;
  wire scl_fall = !scl_f && scl_d_reg;
  // only data edges with clock held high are conditions
  wire start_det = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  wire stop_det = scl_f && scl_d_reg && !sda_d_reg && sda_f;
  wire byte_done = scl_fall && (bitcnt_reg == BITS_PER_BYTE);
  // an unanswered commit counts as busy so polling never races it
  wire busy_link = busy_s2_reg || (req_tgl_reg != ack_s2_reg);
  wire addr_ok = (shreg_reg[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE_CODE)
    && (shreg_reg[ADDR_STRAP_MSB:ADDR_STRAP_LSB] == strap_s2_reg)
    && !busy_link;
  wire [3:0] sh_op = shreg_reg[INSTR_OP_MSB:INSTR_OP_LSB];
  wire [3:0] cur_op = instr_reg[INSTR_OP_MSB:INSTR_OP_LSB];
  wire sh_is_read = (sh_op == OP_RD_WIPER) || (sh_op == OP_RD_NV);
  wire cur_is_write = (cur_op == OP_WR_WIPER) || (cur_op == OP_WR_NV);
  wire nv_protected = (cur_op == OP_WR_NV) && !wp_s2_reg;

  always_comb begin
    lstate_next = lstate_reg;
    bitcnt_next = bitcnt_reg;
    byte_idx_next = byte_idx_reg;
    shreg_next = shreg_reg;
    instr_next = instr_reg;
    data_next = data_reg;
    tx_next = tx_reg;
    is_read_next = is_read_reg;
    wr_pend_next = wr_pend_reg;
    oe_n_next = oe_n_reg;
    req_tgl_next = req_tgl_reg;
    req_next = req_reg;
    if (stop_det) begin
      lstate_next = L_IDLE;
      oe_n_next = 1'b1;
      if (wr_pend_reg) begin
        req_next = '{commit: 1'b1, instr: instr_reg, data: data_reg};
        req_tgl_next = !req_tgl_reg;
        wr_pend_next = 1'b0;
      end
    end else if (start_det) begin
      // repeated start drops any uncommitted write
      lstate_next = L_RX;
      bitcnt_next = '0;
      byte_idx_next = '0;
      is_read_next = 1'b0;
      wr_pend_next = 1'b0;
      oe_n_next = 1'b1;
    end else begin
      case (lstate_reg)
        L_RX: begin
          if (scl_rise) begin
            shreg_next = {shreg_reg[6:0], sda_f};
            bitcnt_next = bitcnt_reg + 4'h1;
          end
          if (byte_done) begin
            bitcnt_next = '0;
            if (byte_idx_reg != 2'h3) begin
              byte_idx_next = byte_idx_reg + 2'h1;
            end
            if (byte_idx_reg == 2'h0) begin
              lstate_next = addr_ok ? L_ACK : L_IGN;
              oe_n_next = !addr_ok;
            end else if (byte_idx_reg == 2'h1) begin
              instr_next = shreg_reg;
              lstate_next = L_ACK;
              oe_n_next = 1'b0;
              is_read_next = sh_is_read;
              if (sh_is_read) begin
                req_next = '{commit: 1'b0, instr: shreg_reg, data: 8'h00};
                req_tgl_next = !req_tgl_reg;
              end
            end else if (nv_protected) begin
              lstate_next = L_IGN;
              oe_n_next = 1'b1;
            end else begin
              data_next = shreg_reg;
              lstate_next = L_ACK;
              oe_n_next = 1'b0;
              wr_pend_next = cur_is_write;
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            bitcnt_next = '0;
            if (is_read_reg) begin
              lstate_next = L_TX;
              tx_next = rd_word;
              oe_n_next = rd_word[7];
            end else begin
              lstate_next = L_RX;
              oe_n_next = 1'b1;
            end
          end
        end
        L_TX: begin
          if (scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
          end
          if (byte_done) begin
            lstate_next = L_RACK;
            oe_n_next = 1'b1;
            bitcnt_next = '0;
          end else if (scl_fall) begin
            tx_next = {tx_reg[6:0], 1'b1};
            oe_n_next = tx_reg[6];
          end
        end
        L_RACK: begin
          if (scl_rise) begin
            shreg_next = {shreg_reg[6:0], sda_f};
          end
          if (scl_fall) begin
            if (!shreg_reg[0]) begin
              lstate_next = L_TX;
              tx_next = rd_word;
              oe_n_next = rd_word[7];
            end else begin
              lstate_next = L_IGN;
              oe_n_next = 1'b1;
            end
          end
        end
        L_IDLE, L_IGN: begin
          oe_n_next = 1'b1;
        end
        default: begin
          lstate_next = L_IDLE;
          oe_n_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      strap_s1_reg <= {i_addr_strap_3, i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
      strap_s2_reg <= strap_s1_reg;
      wp_s1_reg <= i_wp_n;
      wp_s2_reg <= wp_s1_reg;
      busy_s1_reg <= o_prog_busy;
      busy_s2_reg <= busy_s1_reg;
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      lstate_reg <= L_IDLE;
      bitcnt_reg <= '0;
      byte_idx_reg <= '0;
      shreg_reg <= '0;
      instr_reg <= '0;
      data_reg <= '0;
      tx_reg <= '0;
      is_read_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      req_tgl_reg <= 1'b0;
      req_reg <= '0;
      o_sda_o <= 1'b0;
    end else begin
      lstate_reg <= lstate_next;
      bitcnt_reg <= bitcnt_next;
      byte_idx_reg <= byte_idx_next;
      shreg_reg <= shreg_next;
      instr_reg <= instr_next;
      data_reg <= data_next;
      tx_reg <= tx_next;
      is_read_reg <= is_read_next;
      wr_pend_reg <= wr_pend_next;
      oe_n_reg <= oe_n_next;
      req_tgl_reg <= req_tgl_next;
      req_reg <= req_next;
      o_sda_o <= 1'b0;
    end
  end
  assign o_sda_oe_n = oe_n_reg;

  // ---------------- core domain ----------------
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic busy_reg;
  logic [CW-1:0] prog_cnt_reg;
  logic load_done_reg;
  logic [7:0] rd_word_reg;
  logic [WIPER_W-1:0] nv_reg [0:NUM_POTS*NUM_NV_PER_POT-1];
  logic [WIPER_W-1:0] wiper_reg [0:NUM_POTS-1];

  // payload is held by the link side until the answering toggle returns
  wire req_evt = req_s2_reg != req_s3_reg;
  wire [3:0] rq_op = req_reg.instr[INSTR_OP_MSB:INSTR_OP_LSB];
  wire [1:0] rq_pot = req_reg.instr[INSTR_POT_MSB:INSTR_POT_LSB];
  wire [1:0] rq_sel = req_reg.instr[INSTR_REG_MSB:INSTR_REG_LSB];
  wire [3:0] rq_idx = {rq_pot, rq_sel};
  wire wr_wiper_hit = req_evt && req_reg.commit && (rq_op == OP_WR_WIPER);
  wire wr_nv_hit = req_evt && req_reg.commit && (rq_op == OP_WR_NV);
  wire [7:0] rd_mux = (rq_op == OP_RD_WIPER) ? {2'b00, wiper_reg[rq_pot]}
    : {2'b00, nv_reg[rq_idx]};
  wire prog_last = busy_reg && (prog_cnt_reg == '0);
  assign rd_word = rd_word_reg;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rd_word_reg <= '0;
      load_done_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      load_done_reg <= 1'b1;
      if (req_evt) begin
        ack_tgl_reg <= !ack_tgl_reg;
        if (!req_reg.commit) begin
          rd_word_reg <= rd_mux;
        end
      end
    end
  end

  // the count runs on alone once loaded; protection is not looked at here
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (wr_nv_hit) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= PROG_LOAD;
    end else if (prog_last) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      prog_cnt_reg <= prog_cnt_reg - 1'b1;
    end
  end
  assign o_prog_busy = busy_reg;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_POTS * NUM_NV_PER_POT; i++) begin
        nv_reg[i] <= NV_RESET;
      end
    end else if (wr_nv_hit) begin
      nv_reg[rq_idx] <= req_reg.data[WIPER_W-1:0];
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_POTS; gp++) begin : g_pot
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          wiper_reg[gp] <= WIPER_RESET;
        end else if (!load_done_reg) begin
          wiper_reg[gp] <= nv_reg[gp*NUM_NV_PER_POT];
        end else if (wr_wiper_hit && (rq_pot == gp)) begin
          wiper_reg[gp] <= req_reg.data[WIPER_W-1:0];
        end
      end
      assign o_wiper_pos[gp] = wiper_reg[gp];
    end
  endgenerate

  // ---------------- checks ----------------
  a_idle_released: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (lstate_reg == L_IDLE) |-> oe_n_reg) else $error("line driven while idle");
  a_start_release: assert property (@(posedge i_link_clk) disable iff (i_rst)
    start_det |=> (oe_n_reg && lstate_reg == L_RX)) else $error("start not taken");
  a_addr_ack: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (lstate_reg == L_RX && byte_done && byte_idx_reg == 2'h0 && addr_ok && !start_det
    && !stop_det) |=> !oe_n_reg) else $error("matched address not acked");
  a_addr_mismatch: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (lstate_reg == L_RX && byte_done && byte_idx_reg == 2'h0 && !addr_ok && !start_det
    && !stop_det) |=> (oe_n_reg && lstate_reg == L_IGN)) else $error("bad ack");
  a_busy_silent: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (busy_s2_reg && lstate_reg == L_RX && byte_idx_reg == 2'h0)
    |=> (lstate_reg != L_ACK)) else $error("acked while programming");
  a_wp_nack: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (lstate_reg == L_RX && byte_done && byte_idx_reg[1] && nv_protected && !start_det
    && !stop_det) |=> (oe_n_reg && !wr_pend_reg)) else $error("protected data acked");
  a_nack_stop: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (lstate_reg == L_RACK && scl_fall && shreg_reg[0] && !start_det && !stop_det)
    |=> (lstate_reg == L_IGN) ##1 oe_n_reg) else $error("sent after nack");
  a_stop_commit: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (stop_det && wr_pend_reg) |=> (req_tgl_reg != $past(req_tgl_reg) && req_reg.commit))
    else $error("write not committed at stop");
  a_prog_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_nv_hit |=> (busy_reg && prog_cnt_reg == PROG_LOAD)) else $error("cycle not started");
  a_prog_runs: assert property (@(posedge i_mclk) disable iff (i_rst)
    (busy_reg && !prog_last) |=> busy_reg) else $error("cycle cut short");
  a_wiper_fast: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_wiper_hit && !busy_reg) |=> !busy_reg) else $error("wiper write went busy");
  a_powerup_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(load_done_reg) |-> (wiper_reg[0] == nv_reg[0] && wiper_reg[3] == nv_reg[12]))
    else $error("wiper not loaded at power-up");

  c_read_byte: cover property (@(posedge i_link_clk) disable iff (i_rst)
    lstate_reg == L_RACK && scl_fall && !shreg_reg[0]);
  c_prog_cycle: cover property (@(posedge i_mclk) disable iff (i_rst) wr_nv_hit);
  c_poll_nack: cover property (@(posedge i_link_clk) disable iff (i_rst)
    busy_s2_reg && lstate_reg == L_IGN);
endmodule

// ---- qpot_bus_master.sv ----
// behavioural two-wire bus master that drives the port's serial pins
`timescale 1ns/10ps
module qpot_bus_master #(
  parameter int T_NS = 300
) (
  // wire level seen and levels driven
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_drv
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end
  // data falls with clock high, clock left low
  task automatic start();
    o_sda_drv = 1'b1;
    #(T_NS) o_scl = 1'b1;
    #(2*T_NS) o_sda_drv = 1'b0;
    #(2*T_NS) o_scl = 1'b0;
  endtask
  // ends the frame, then keeps the bus free before the next one
  task automatic stop();
    #(T_NS) o_sda_drv = 1'b0;
    #(3*T_NS) o_scl = 1'b1;
    #(2*T_NS) o_sda_drv = 1'b1;
    #(4*T_NS);
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic got);
    #(T_NS) o_sda_drv = b;
    #(3*T_NS) o_scl = 1'b1;
    #(T_NS) got = i_sda;
    #(T_NS) o_scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], g);
    end
    bit_io(1'b1, g);
    ack = ~g;
  endtask
  task automatic recv_byte(input logic ack_m, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, g);
      d[i] = g;
    end
    bit_io(~ack_m, g);
  endtask
endmodule

// ---- qpot_i2c_slave_port_bench.sv ----
// self-checking bench for the quad potentiometer serial slave port
`timescale 1ns/10ps
module qpot_i2c_slave_port_bench
  import qpot_pkg::*;
;
  // short programming time keeps the run brief
  localparam int PROG_P = 4000;
  localparam logic [7:0] ADDR = {DEV_TYPE_CODE, 4'h5};
  logic i_mclk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wp_n = 1'b1;
  logic [3:0] strap = 4'h5;
  logic scl, sda_drv, sda_o, sda_oe_n, busy, a, rel;
  logic [NUM_POTS-1:0][WIPER_W-1:0] wiper;
  logic [2:0] k;
  logic [7:0] rd0, rd1;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  // open drain with pull-up
  wire logic sda = sda_drv & (sda_oe_n | sda_o);

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  // link clock offset so its edges never line up with the core clock
  initial begin
    #3;
    forever #16 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      wrap_up();
    end
  end

  qpot_i2c_slave_port #(.PROG_CYCLES_P(PROG_P)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
    .i_addr_strap_0(strap[0]), .i_addr_strap_1(strap[1]),
    .i_addr_strap_2(strap[2]), .i_addr_strap_3(strap[3]),
    .i_wp_n(i_wp_n), .o_wiper_pos(wiper), .o_prog_busy(busy)
  );
  qpot_bus_master m (.i_sda(sda), .o_scl(scl), .o_sda_drv(sda_drv));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr3(input logic [7:0] ins, input logic [7:0] d);
    m.start();
    m.send_byte(ADDR, k[2]);
    m.send_byte(ins, k[1]);
    m.send_byte(d, k[0]);
    m.stop();
  endtask
  task automatic poll(input logic [7:0] ad);
    m.start();
    m.send_byte(ad, a);
    m.stop();
  endtask
  // a continuing device would pull the line low for the next msb of 0
  task automatic rd(input logic [7:0] ins, input logic twice);
    m.start();
    m.send_byte(ADDR, a);
    m.send_byte(ins, a);
    m.recv_byte(twice, rd0);
    if (twice) begin
      m.recv_byte(1'b0, rd1);
    end
    #1000;
    rel = sda_oe_n;
    m.stop();
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    // look between edges, where the flag has settled
    while (busy !== lvl && n < PROG_P + 50) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  initial begin
    repeat (2) @(posedge i_link_clk);
    @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (40) @(posedge i_mclk);
    for (int p = 0; p < NUM_POTS; p++) begin
      chk({2'b00, wiper[p]}, 8'h20);
    end
    chk({7'h00, sda_oe_n}, 8'h01);
    poll({DEV_TYPE_CODE, 4'h6});
    chk({7'h00, a}, 8'h00);
    poll({DEV_TYPE_CODE ^ 4'h1, 4'h5});
    chk({7'h00, a}, 8'h00);
    // moved straps: the address refused above must now be taken
    @(posedge i_mclk);
    #1 strap = 4'h6;
    poll({DEV_TYPE_CODE, 4'h6});
    chk({7'h00, a}, 8'h01);
    @(posedge i_mclk);
    #1 strap = 4'h5;
    wr3({OP_WR_WIPER, 4'h1}, 8'h15);
    chk({5'h00, k}, 8'h07);
    repeat (20) @(posedge i_mclk);
    chk({2'b00, wiper[1]}, 8'h15);
    chk({7'h00, busy}, 8'h00);
    poll(ADDR);
    chk({7'h00, a}, 8'h01);
    rd({OP_RD_WIPER, 4'h1}, 1'b1);
    chk(rd0, 8'h15);
    chk(rd1, 8'h15);
    chk({7'h00, rel}, 8'h01);
    wr3({OP_WR_NV, 4'he}, 8'h2a);
    wait_busy(1'b1);
    t0 = cyc;
    chk({7'h00, busy}, 8'h01);
    poll(ADDR);
    chk({7'h00, a}, 8'h00);
    wait_busy(1'b0);
    chk((cyc - t0 <= PROG_P + 3) ? 8'h01 : 8'h00, 8'h01);
    repeat (4) @(posedge i_mclk);
    poll(ADDR);
    chk({7'h00, a}, 8'h01);
    rd({OP_RD_NV, 4'he}, 1'b0);
    chk(rd0, 8'h2a);
    chk({2'b00, wiper[2]}, 8'h20);
    wr3({OP_WR_NV, 4'h3}, 8'h11);
    wait_busy(1'b1);
    @(posedge i_mclk);
    #1 i_wp_n = 1'b0;
    t0 = cyc;
    wait_busy(1'b0);
    // an aborted cycle would drop busy almost at once
    chk((cyc - t0 >= PROG_P - 200) ? 8'h01 : 8'h00, 8'h01);
    @(posedge i_mclk);
    #1 i_wp_n = 1'b1;
    rd({OP_RD_NV, 4'h3}, 1'b0);
    chk(rd0, 8'h11);
    @(posedge i_mclk);
    #1 i_wp_n = 1'b0;
    wr3({OP_WR_NV, 4'h0}, 8'h07);
    chk({5'h00, k}, 8'h06);
    repeat (20) @(posedge i_mclk);
    chk({7'h00, busy}, 8'h00);
    rd({OP_RD_NV, 4'h0}, 1'b0);
    chk(rd0, 8'h20);
    wrap_up();
  end
endmodule
